/* logic/dma_serial_port.sv */
`timescale 1ns/1ps
// ==================================================
// Function
// - without flow control, both handshakes asserted
// - optional even parity, generated and checked
// - stop-bit count chosen in configuration
// - every stop task issued while enabled gets its stop event, unless disabled before the stop completes
// - pin selects act only while enabled
// - pin selects kept while powered on
// - clear-to-send low permits, high withholds
// - request-to-send low invites, high refuses
// - error source: write one clears bit
// - shortcuts let events fire tasks
// - bit-rate register sets serial timing
// - read-only counts of bytes moved
// - limit registers bound bytes per buffer
// - one register holds parity and flow
// - four pin selects in fixed order
// - characters travel least significant bit first
// - flow control pauses after current byte
// - request-to-send drops when stopped or full
module dma_serial_port (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic [31:0] gpio_in,
	output logic [31:0]      gpio_out,
	output logic [31:0]      gpio_oe,
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	output logic [7:0]       rx_data,
	output logic             rx_valid,
	input  wire logic        rx_ready,
	output logic [31:0]      tx_ptr,
	output logic [31:0]      rx_ptr
);
	serial_port_pkg::top_state_t s, n;
	serial_port_pkg::frame_t     rxf;
	logic [10:0]                 ev_set;
	logic [3:0]                  err_set;
	logic [4:0]                  rts_i, txd_i, cts_i, rxd_i;
	logic [15:0]                 tx_now, rx_now;
	logic                        en_on, par_on, wr, cts_lvl, cts_ok, rts_on;
	logic                        rx_line, txb, txdone, txline, tx_go, rxb, rxv;
	logic                        t_srx, t_prx, t_stx, t_ptx, t_flush, store, do_endrx;

	// ==================================================
	// pin routing
	assign en_on = s.en == serial_port_pkg::ENABLE_ON;
	assign par_on = s.cfg.parity == serial_port_pkg::PAR_EVEN;
	assign rts_i = s.psel[0][4:0];
	assign txd_i = s.psel[1][4:0];
	assign cts_i = s.psel[2][4:0];
	assign rxd_i = s.psel[3][4:0];
	assign cts_lvl = (en_on && serial_port_pkg::pin_on(s.psel[2])) ? s.s2[cts_i] : 1'b1;
	assign rx_line = (en_on && serial_port_pkg::pin_on(s.psel[3])) ? s.s2[rxd_i] : 1'b1;
	// active-low clear-to-send; ignored without flow control
	assign cts_ok = !s.cfg.flow || !serial_port_pkg::pin_on(s.psel[2]) || !cts_lvl;
	// request asserted while receiving and the holding byte is free
	assign rts_on = s.cfg.flow ? (s.rxm == serial_port_pkg::RX_RUN && !s.hold) : 1'b1;
	// only start a byte between frames, so a paused byte always completes
	assign tx_ready = en_on && s.txm == serial_port_pkg::TX_RUN && !txb && cts_ok
		&& s.tx_cnt < s.tx_lim;
	assign tx_go = tx_valid && tx_ready;

	// ==================================================
	// task strobes
	assign wr = s.a_ok && s.a_wr;
	assign t_srx = (wr && s.a_adr == serial_port_pkg::OFF_START_RX && hwdata[0]) || s.sc_srx;
	assign t_prx = (wr && s.a_adr == serial_port_pkg::OFF_STOP_RX && hwdata[0]) || s.sc_prx;
	assign t_stx = wr && s.a_adr == serial_port_pkg::OFF_START_TX && hwdata[0];
	assign t_ptx = wr && s.a_adr == serial_port_pkg::OFF_STOP_TX && hwdata[0];
	assign t_flush = wr && s.a_adr == serial_port_pkg::OFF_FLUSH_RX && hwdata[0];
	assign tx_now = txdone ? s.tx_cnt + 16'h1 : s.tx_cnt;
	assign rx_now = store ? s.rx_cnt + 16'h1 : s.rx_cnt;

	tx_shifter u_tx (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.start    (tx_go),
		.data     (tx_data),
		.inc      (s.rate),
		.par_en   (par_on),
		.two_stop (s.cfg.two_stop),
		.busy     (txb),
		.done     (txdone),
		.line     (txline)
	);

	rx_sampler u_rx (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (en_on),
		.line    (rx_line),
		.inc     (s.rate),
		.par_en  (par_on),
		.busy    (rxb),
		.valid   (rxv),
		.frame   (rxf)
	);

	// ==================================================
	// next state
	always_comb begin
		n = s;
		ev_set = '0;
		err_set = '0;
		store = 1'b0;
		do_endrx = 1'b0;
		n.s1 = gpio_in;
		n.s2 = s.s1;
		// bus address phase, read word captured for the data phase
		n.a_ok = hsel && hready && htrans[1] && hsize == 3'h2;
		n.a_wr = hwrite;
		n.a_adr = haddr[11:0];
		unique case (haddr[11:0])
			serial_port_pkg::OFF_SHORTCUT: n.rdata = {25'h0, s.shortcut, 5'h0};
			serial_port_pkg::OFF_INTERRUPT_ENABLE,
			serial_port_pkg::OFF_INTSET,
			serial_port_pkg::OFF_INTCLR: n.rdata = s.interrupt_enable;
			serial_port_pkg::OFF_ERRSRC: n.rdata = {28'h0, s.err};
			serial_port_pkg::OFF_ENABLE: n.rdata = {28'h0, s.en};
			serial_port_pkg::OFF_RATE: n.rdata = s.rate;
			serial_port_pkg::OFF_RX_PTR: n.rdata = s.rx_ptr;
			serial_port_pkg::OFF_RX_LIM: n.rdata = {16'h0, s.rx_lim};
			serial_port_pkg::OFF_RX_AMT: n.rdata = {16'h0, s.rx_amt};
			serial_port_pkg::OFF_TX_PTR: n.rdata = s.tx_ptr;
			serial_port_pkg::OFF_TX_LIM: n.rdata = {16'h0, s.tx_lim};
			serial_port_pkg::OFF_TX_AMT: n.rdata = {16'h0, s.tx_amt};
			serial_port_pkg::OFF_CONFIG: n.rdata = {27'h0, s.cfg};
			default: n.rdata = '0;
		endcase
		for (int i = 0; i < 4; i++) begin
			if (haddr[11:0] == serial_port_pkg::PSEL_OFF[i]) n.rdata = s.psel[i];
		end
		for (int i = 0; i < serial_port_pkg::EV_N; i++) begin
			if (haddr[11:0] == serial_port_pkg::EV_OFF[i]) n.rdata = {31'h0, s.ev[i]};
		end

		// bus data phase writes
		if (wr) begin
			unique case (s.a_adr)
				serial_port_pkg::OFF_SHORTCUT: n.shortcut = hwdata[6:5];
				serial_port_pkg::OFF_INTERRUPT_ENABLE: n.interrupt_enable = hwdata;
				serial_port_pkg::OFF_INTSET: n.interrupt_enable = s.interrupt_enable | hwdata;
				serial_port_pkg::OFF_INTCLR: n.interrupt_enable = s.interrupt_enable & ~hwdata;
				serial_port_pkg::OFF_ERRSRC: n.err = s.err & ~hwdata[3:0];
				serial_port_pkg::OFF_ENABLE: n.en = hwdata[3:0];
				serial_port_pkg::OFF_RATE: n.rate = hwdata;
				serial_port_pkg::OFF_RX_PTR: n.rx_ptr = hwdata;
				serial_port_pkg::OFF_RX_LIM: n.rx_lim = hwdata[15:0];
				serial_port_pkg::OFF_TX_PTR: n.tx_ptr = hwdata;
				serial_port_pkg::OFF_TX_LIM: n.tx_lim = hwdata[15:0];
				serial_port_pkg::OFF_CONFIG: n.cfg = hwdata[4:0];
				default: begin
				end
			endcase
			// pin selects survive only in registers, set to all ones by reset alone
			for (int i = 0; i < 4; i++) begin
				if (s.a_adr == serial_port_pkg::PSEL_OFF[i]) n.psel[i] = hwdata;
			end
			for (int i = 0; i < serial_port_pkg::EV_N; i++) begin
				if (s.a_adr == serial_port_pkg::EV_OFF[i]) n.ev[i] = hwdata[0];
			end
		end

		// clear-to-send edges
		n.cts_q = cts_lvl;
		if (s.cts_q && !cts_lvl) ev_set[serial_port_pkg::EV_CTS] = 1'b1;
		if (!s.cts_q && cts_lvl) ev_set[serial_port_pkg::EV_NCTS] = 1'b1;

		// transmit direction
		if (txdone) begin
			ev_set[serial_port_pkg::EV_TXRDY] = 1'b1;
			n.tx_cnt = tx_now;
			if (tx_now == s.tx_lim && !s.tx_endd) begin
				ev_set[serial_port_pkg::EV_ENDTX] = 1'b1;
				n.tx_endd = 1'b1;
				n.tx_amt = tx_now;
			end
		end
		if (!en_on) begin
			n.txm = serial_port_pkg::TX_IDLE;
		end else begin
			unique case (s.txm)
				serial_port_pkg::TX_IDLE, serial_port_pkg::TX_RUN: begin
					if (t_ptx) begin
						n.txm = serial_port_pkg::TX_STOP;
					end else if (t_stx) begin
						n.txm = serial_port_pkg::TX_RUN;
						n.tx_cnt = '0;
						n.tx_endd = 1'b0;
						ev_set[serial_port_pkg::EV_TXSTART] = 1'b1;
					end
				end
				serial_port_pkg::TX_STOP: begin
					// acknowledge once the byte on the line has finished
					if (!txb) begin
						n.txm = serial_port_pkg::TX_IDLE;
						ev_set[serial_port_pkg::EV_TXSTOP] = 1'b1;
						if (!s.tx_endd) begin
							ev_set[serial_port_pkg::EV_ENDTX] = 1'b1;
							n.tx_endd = 1'b1;
							n.tx_amt = s.tx_cnt;
						end
					end
				end
			endcase
		end

		// receive direction
		if (s.hold && rx_ready) n.hold = 1'b0;
		if (rxv) begin
			ev_set[serial_port_pkg::EV_RXRDY] = 1'b1;
			err_set[serial_port_pkg::ERR_PAR] = rxf.perr;
			err_set[serial_port_pkg::ERR_FRM] = rxf.ferr;
			err_set[serial_port_pkg::ERR_BRK] = rxf.brk;
			if (!rxf.ferr && s.rxm != serial_port_pkg::RX_IDLE) begin
				if ((!s.hold || rx_ready) && !s.rx_endd) begin
					store = 1'b1;
					n.hold = 1'b1;
					n.hold_d = rxf.data;
				end else begin
					err_set[serial_port_pkg::ERR_OVR] = 1'b1;
				end
			end
		end
		if (store) begin
			n.rx_cnt = rx_now;
			if (rx_now == s.rx_lim) do_endrx = 1'b1;
		end
		if (!en_on) begin
			n.rxm = serial_port_pkg::RX_IDLE;
		end else begin
			unique case (s.rxm)
				serial_port_pkg::RX_IDLE, serial_port_pkg::RX_RUN: begin
					if (t_prx) begin
						n.rxm = serial_port_pkg::RX_STOP;
					end else if (t_srx) begin
						n.rxm = serial_port_pkg::RX_RUN;
						n.rx_cnt = '0;
						n.rx_endd = 1'b0;
						ev_set[serial_port_pkg::EV_RXSTART] = 1'b1;
					end
				end
				serial_port_pkg::RX_STOP: begin
					// buffer end is reported one cycle ahead of the timeout
					if (!rxb && !s.rx_endd) begin
						do_endrx = 1'b1;
					end else if (!rxb) begin
						n.rxm = serial_port_pkg::RX_IDLE;
						ev_set[serial_port_pkg::EV_RX_TIMEOUT] = 1'b1;
					end
				end
			endcase
		end
		if (t_flush) begin
			ev_set[serial_port_pkg::EV_ENDRX] = 1'b1;
			n.rx_amt = '0;
		end
		if (do_endrx && !s.rx_endd) begin
			ev_set[serial_port_pkg::EV_ENDRX] = 1'b1;
			n.rx_endd = 1'b1;
			n.rx_amt = rx_now;
		end
		n.sc_srx = ev_set[serial_port_pkg::EV_ENDRX] && s.shortcut[0];
		n.sc_prx = ev_set[serial_port_pkg::EV_ENDRX] && s.shortcut[1];

		// hardware set beats a software clear in the same cycle
		if (|err_set) ev_set[serial_port_pkg::EV_ERROR] = 1'b1;
		n.err = n.err | err_set;
		n.ev = n.ev | ev_set;

		// pins driven only while enabled, otherwise released
		n.pin_o = '0;
		n.pin_oe = '0;
		if (en_on) begin
			if (serial_port_pkg::pin_on(s.psel[1])) begin
				n.pin_o[txd_i] = txline;
				n.pin_oe[txd_i] = 1'b1;
			end
			if (serial_port_pkg::pin_on(s.psel[0])) begin
				n.pin_o[rts_i] = !rts_on;
				n.pin_oe[rts_i] = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.s1 <= '1;
			s.s2 <= '1;
			s.psel <= {4{serial_port_pkg::PSEL_RST}};
			s.rate <= serial_port_pkg::RATE_RST;
			s.cts_q <= 1'b1;
			s.tx_endd <= 1'b1;
			s.rx_endd <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ==================================================
	// outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign gpio_out = s.pin_o;
	assign gpio_oe = s.pin_oe;
	assign rx_data = s.hold_d;
	assign rx_valid = s.hold;
	assign tx_ptr = s.tx_ptr;
	assign rx_ptr = s.rx_ptr;

	// ==================================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence rx_drained;
		s.rxm == serial_port_pkg::RX_STOP && !rxb && !s.rx_endd && en_on;
	endsequence
	sequence end_then_timeout;
		s.ev[serial_port_pkg::EV_ENDRX] ##1 s.ev[serial_port_pkg::EV_RX_TIMEOUT];
	endsequence

	rts_no_flow_a: assert property (en_on && !s.cfg.flow && serial_port_pkg::pin_on(s.psel[0])
		&& $stable(s.psel[0]) |=> gpio_oe[$past(rts_i)] && !gpio_out[$past(rts_i)])
		else $error("request-to-send not asserted without flow control");
	tx_stop_ack_a: assert property (s.txm == serial_port_pkg::TX_STOP && !txb && en_on
		|=> s.ev[serial_port_pkg::EV_TXSTOP] && s.txm == serial_port_pkg::TX_IDLE)
		else $error("no transmitter-stopped event");
	rx_stop_ack_a: assert property (rx_drained ##1 (!rxb && en_on) |-> end_then_timeout)
		else $error("receive timeout missing or out of order");
	pins_released_a: assert property (!en_on |=> gpio_oe == 32'h0)
		else $error("pins driven while disabled");
	cts_hold_a: assert property (en_on && s.cfg.flow && serial_port_pkg::pin_on(s.psel[2])
		&& cts_lvl |-> !tx_ready) else $error("byte offered while clear-to-send high");
	rts_refuse_a: assert property (en_on && s.cfg.flow && serial_port_pkg::pin_on(s.psel[0])
		&& (s.rxm != serial_port_pkg::RX_RUN || s.hold) |=> gpio_out[$past(rts_i)])
		else $error("request-to-send low while unable to take data");
	err_clear_a: assert property (wr && s.a_adr == serial_port_pkg::OFF_ERRSRC && hwdata[1]
		&& !(rxv && rxf.perr) |=> !s.err[serial_port_pkg::ERR_PAR]) else $error("error bit not cleared");
	short_start_a: assert property (ev_set[serial_port_pkg::EV_ENDRX] && s.shortcut == 2'b01
		&& en_on && s.rxm == serial_port_pkg::RX_RUN && !t_prx ##1 (en_on && !t_prx)
		|-> ##1 s.ev[serial_port_pkg::EV_RXSTART]) else $error("shortcut did not restart receiver");
	tx_amount_a: assert property (txdone && tx_now == s.tx_lim && !s.tx_endd
		|=> s.ev[serial_port_pkg::EV_ENDTX] && s.tx_amt == s.tx_lim) else $error("transmit count wrong");
endmodule : dma_serial_port

/* logic/rx_sampler.sv */
`timescale 1ns/1ps
module rx_sampler (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   run,
	input  wire logic                   line,
	input  wire logic [31:0]            inc,
	input  wire logic                   par_en,
	output logic                        busy,
	output logic                        valid,
	output serial_port_pkg::frame_t     frame
);
	serial_port_pkg::rx_eng_t s, n;
	logic [32:0]              step;

	always_comb begin
		n = s;
		step = serial_port_pkg::rate_step(s.acc, inc);
		valid = 1'b0;
		frame = '0;
		if (!run) begin
			n.ph = serial_port_pkg::RB_IDLE;
		end else if (s.ph == serial_port_pkg::RB_IDLE) begin
			if (!line) begin
				n.ph = serial_port_pkg::RB_START;
				n.acc = serial_port_pkg::ACC_HALF;
			end
		end else begin
			n.acc = step[31:0];
			if (step[32]) begin
				unique case (s.ph)
					serial_port_pkg::RB_START: begin
						n.ph = line ? serial_port_pkg::RB_IDLE : serial_port_pkg::RB_DATA;
						n.cnt = '0;
					end
					serial_port_pkg::RB_DATA: begin
						n.sh = {line, s.sh[7:1]};
						n.cnt = s.cnt + 3'h1;
						if (s.cnt == 3'h7) begin
							n.ph = par_en ? serial_port_pkg::RB_PAR : serial_port_pkg::RB_STOP;
						end
					end
					serial_port_pkg::RB_PAR: begin
						n.pbit = line;
						n.ph = serial_port_pkg::RB_STOP;
					end
					serial_port_pkg::RB_STOP: begin
						valid = 1'b1;
						frame.data = s.sh;
						frame.perr = par_en && (s.pbit != serial_port_pkg::even_par(s.sh));
						frame.ferr = !line;
						frame.brk = !line && s.sh == 8'h00;
						n.ph = serial_port_pkg::RB_IDLE;
					end
					serial_port_pkg::RB_IDLE: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign busy = s.ph != serial_port_pkg::RB_IDLE;
endmodule : rx_sampler

/* logic/serial_port_pkg.sv */
package serial_port_pkg;
	// ==================================================
	// register offsets
	localparam logic [11:0] OFF_START_RX = 12'h000;
	localparam logic [11:0] OFF_STOP_RX  = 12'h004;
	localparam logic [11:0] OFF_START_TX = 12'h008;
	localparam logic [11:0] OFF_STOP_TX  = 12'h00c;
	localparam logic [11:0] OFF_FLUSH_RX = 12'h02c;
	localparam logic [11:0] OFF_SHORTCUT = 12'h200;
	localparam logic [11:0] OFF_INTERRUPT_ENABLE    = 12'h300;
	localparam logic [11:0] OFF_INTSET   = 12'h304;
	localparam logic [11:0] OFF_INTCLR   = 12'h308;
	localparam logic [11:0] OFF_ERRSRC   = 12'h480;
	localparam logic [11:0] OFF_ENABLE   = 12'h500;
	localparam logic [11:0] OFF_RATE     = 12'h524;
	localparam logic [11:0] OFF_RX_PTR   = 12'h534;
	localparam logic [11:0] OFF_RX_LIM   = 12'h538;
	localparam logic [11:0] OFF_RX_AMT   = 12'h53c;
	localparam logic [11:0] OFF_TX_PTR   = 12'h544;
	localparam logic [11:0] OFF_TX_LIM   = 12'h548;
	localparam logic [11:0] OFF_TX_AMT   = 12'h54c;
	localparam logic [11:0] OFF_CONFIG   = 12'h56c;
	// pin selects: 0 request-to-send, 1 transmit, 2 clear-to-send, 3 receive
	localparam logic [3:0][11:0] PSEL_OFF = {12'h514, 12'h510, 12'h50c, 12'h508};
	localparam int EV_N = 11;
	localparam logic [10:0][11:0] EV_OFF = {12'h158, 12'h150, 12'h14c, 12'h144, 12'h124,
		12'h120, 12'h11c, 12'h110, 12'h108, 12'h104, 12'h100};
	localparam int EV_CTS = 0;
	localparam int EV_NCTS = 1;
	localparam int EV_RXRDY = 2;
	localparam int EV_ENDRX = 3;
	localparam int EV_TXRDY = 4;
	localparam int EV_ENDTX = 5;
	localparam int EV_ERROR = 6;
	localparam int EV_RX_TIMEOUT = 7;
	localparam int EV_RXSTART = 8;
	localparam int EV_TXSTART = 9;
	localparam int EV_TXSTOP = 10;
	// ==================================================
	// fields and reset values
	localparam logic [3:0] ENABLE_ON = 4'h8;
	localparam int PSEL_OFF_BIT = 31;
	localparam int PIN_W = 5;
	localparam int SC_END_START = 5;
	localparam int ERR_OVR = 0;
	localparam int ERR_PAR = 1;
	localparam int ERR_FRM = 2;
	localparam int ERR_BRK = 3;
	localparam logic [2:0] PAR_EVEN = 3'h7;
	localparam int LIM_W = 16;
	localparam logic [31:0] PSEL_RST = 32'hffff_ffff;
	localparam logic [31:0] RATE_RST = 32'h0019_2a73;
	localparam logic [31:0] ACC_HALF = 32'h8000_0000;
	localparam logic [3:0] FRAME_BASE = 4'ha;
	// ==================================================
	// types
	typedef enum logic [1:0] {TX_IDLE, TX_RUN, TX_STOP} tx_mode_t;
	typedef enum logic [1:0] {RX_IDLE, RX_RUN, RX_STOP} rx_mode_t;
	typedef enum logic [2:0] {RB_IDLE, RB_START, RB_DATA, RB_PAR, RB_STOP} rx_bit_t;
	typedef struct packed {logic two_stop; logic [2:0] parity; logic flow;} cfg_t;
	typedef struct packed {logic brk; logic ferr; logic perr; logic [7:0] data;} frame_t;
	typedef struct packed {logic [31:0] acc; logic [11:0] sh; logic [3:0] left; logic busy;} tx_eng_t;
	typedef struct packed {rx_bit_t ph; logic [31:0] acc; logic [2:0] cnt; logic [7:0] sh; logic pbit;} rx_eng_t;
	typedef struct packed {
		logic [31:0] s1, s2, pin_o, pin_oe, rdata, interrupt_enable, rate, rx_ptr, tx_ptr;
		logic [3:0][31:0] psel;
		logic [LIM_W-1:0] rx_lim, rx_cnt, rx_amt, tx_lim, tx_cnt, tx_amt;
		logic [3:0] en, err;
		logic [10:0] ev;
		logic [1:0] shortcut;
		cfg_t cfg;
		tx_mode_t txm;
		rx_mode_t rxm;
		logic cts_q, tx_endd, rx_endd, hold, sc_srx, sc_prx, a_ok, a_wr;
		logic [7:0] hold_d;
		logic [11:0] a_adr;
	} top_state_t;

	function automatic logic [32:0] rate_step(input logic [31:0] acc, input logic [31:0] inc);
		rate_step = {1'b0, acc} + {1'b0, inc};
	endfunction : rate_step

	function automatic logic even_par(input logic [7:0] d);
		even_par = ^d;
	endfunction : even_par

	function automatic logic pin_on(input logic [31:0] p);
		pin_on = !p[PSEL_OFF_BIT];
	endfunction : pin_on
endpackage : serial_port_pkg

/* logic/tx_shifter.sv */
`timescale 1ns/1ps
module tx_shifter (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        start,
	input  wire logic [7:0]  data,
	input  wire logic [31:0] inc,
	input  wire logic        par_en,
	input  wire logic        two_stop,
	output logic             busy,
	output logic             done,
	output logic             line
);
	serial_port_pkg::tx_eng_t s, n;
	logic [32:0]              step;
	logic [3:0]               ticks_q, exp_q;

	always_comb begin
		n = s;
		step = serial_port_pkg::rate_step(s.acc, inc);
		done = 1'b0;
		if (start && !s.busy) begin
			n.busy = 1'b1;
			n.acc = '0;
			// start bit, data lsb first, parity after data, then stops
			n.sh = par_en ? {2'b11, serial_port_pkg::even_par(data), data, 1'b0}
				: {3'b111, data, 1'b0};
			n.left = serial_port_pkg::FRAME_BASE + {3'h0, par_en} + {3'h0, two_stop};
		end else if (s.busy) begin
			n.acc = step[31:0];
			if (step[32]) begin
				n.sh = {1'b1, s.sh[11:1]};
				n.left = s.left - 4'h1;
				if (s.left == 4'h1) begin
					n.busy = 1'b0;
					done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.sh <= '1;
		end else begin
			s <= n;
		end
	end

	assign busy = s.busy;
	assign line = s.sh[0];

	// bit-time counter for checking frame length
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ticks_q <= '0;
			exp_q <= '0;
		end else if (start && !s.busy) begin
			ticks_q <= '0;
			exp_q <= n.left;
		end else if (s.busy && step[32]) begin
			ticks_q <= ticks_q + 4'h1;
		end
	end

	frame_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
		done |-> ticks_q + 4'h1 == exp_q) else $error("frame bit count wrong");
endmodule : tx_shifter

/* verification/dma_serial_port_tb.sv */
`timescale 1ns/1ps
module dma_serial_port_tb;
	typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cts_n;
	logic        tx_valid, tx_ready, rx_valid, rx_ready, tx_line, rx_line;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, gpio_out, gpio_oe, r, tx_ptr, rx_ptr;
	logic [7:0]  tx_data, rx_data, got;
	int          n_mismatch, checks;
	row_t        rows [19];
	assign hready = hreadyout;
	assign tx_line = gpio_oe[1] ? gpio_out[1] : 1'b1;

	dma_serial_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .gpio_in({28'hfffffff, rx_line, cts_n, 2'h3}),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_ptr(tx_ptr), .rx_ptr(rx_ptr));
	serial_peer peer (.hclk(hclk), .tx_line(tx_line), .rx_line(rx_line), .got(got));

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
		@(posedge hclk);
	endtask : bus

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(r, e);
	endtask : rd_chk

	task automatic tally_and_finish;
		if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		tally_and_finish();
	end

	// ==================================================
	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		tx_data = 8'h00;
		tx_valid = 1'b0;
		rx_ready = 1'b0;
		cts_n = 1'b1;
		n_mismatch = 0;
		checks = 0;
		rows = '{'{0, 12'h508, 0, 32'hffffffff}, '{0, 12'h50c, 0, 32'hffffffff},
			'{0, 12'h510, 0, 32'hffffffff}, '{0, 12'h514, 0, 32'hffffffff}, '{0, 12'h524, 0, 32'h00192a73},
			'{0, 12'h500, 0, 0}, '{0, 12'h56c, 0, 0}, '{1, 12'h508, 0, 0}, '{1, 12'h50c, 1, 1},
			'{1, 12'h510, 2, 2}, '{1, 12'h514, 3, 3}, '{1, 12'h524, 32'h10000000, 32'h10000000},
			'{1, 12'h548, 1, 1}, '{1, 12'h538, 32'h10003, 3}, '{1, 12'h53c, 5, 0},
			'{1, 12'h600, 7, 0}, '{1, 12'h534, 32'h200, 32'h200}, '{1, 12'h544, 32'h300, 32'h300},
			'{1, 12'h56c, 1, 1}};
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) begin
			if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
			rd_chk(rows[i].a, rows[i].e);
		end
		chk(rx_ptr, 32'h200);
		chk(tx_ptr, 32'h300);
		bus(1'b1, 12'h500, 32'h8);
		bus(1'b1, 12'h008, 32'h1);
		chk(gpio_oe & 32'hf, 32'h3);
		chk({31'h0, tx_ready}, 32'h0);
		cts_n <= 1'b0;
		repeat (5) @(posedge hclk);
		chk({31'h0, tx_ready}, 32'h1);
		tx_data <= 8'ha5;
		tx_valid <= 1'b1;
		@(posedge hclk);
		tx_valid <= 1'b0;
		repeat (220) @(posedge hclk);
		chk({24'h0, got}, 32'ha5);
		bus(1'b1, 12'h00c, 32'h1);
		repeat (4) @(posedge hclk);
		rd_chk(12'h158, 32'h1);
		bus(1'b1, 12'h004, 32'h1);
		repeat (4) @(posedge hclk);
		rd_chk(12'h144, 32'h1);
		cts_n <= 1'b1;
		bus(1'b1, 12'h56c, 32'h1e);
		bus(1'b1, 12'h11c, 32'h0);
		bus(1'b1, 12'h008, 32'h1);
		chk({31'h0, tx_ready}, 32'h1);
		chk({31'h0, gpio_out[0]}, 32'h0);
		tx_data <= 8'h97;
		tx_valid <= 1'b1;
		@(posedge hclk);
		tx_valid <= 1'b0;
		repeat (153) @(posedge hclk);
		chk({31'h0, tx_line}, 32'h1);
		repeat (27) @(posedge hclk);
		rd_chk(12'h11c, 32'h0);
		repeat (20) @(posedge hclk);
		rd_chk(12'h11c, 32'h1);
		chk({24'h0, got}, 32'h97);
		bus(1'b1, 12'h56c, 32'hf);
		bus(1'b1, 12'h000, 32'h1);
		repeat (4) @(posedge hclk);
		chk({31'h0, gpio_out[0]}, 32'h0);
		peer.send({1'b1, ~^8'h3c, 8'h3c, 1'b0}, 11);
		chk({23'h0, rx_valid, rx_data}, 32'h13c);
		chk({31'h0, gpio_out[0]}, 32'h1);
		rd_chk(12'h124, 32'h1);
		rd_chk(12'h480, 32'h2);
		bus(1'b1, 12'h480, 32'h0);
		rd_chk(12'h480, 32'h2);
		bus(1'b1, 12'h480, 32'h2);
		rd_chk(12'h480, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		bus(1'b1, 12'h144, 32'h0);
		bus(1'b1, 12'h004, 32'h1);
		repeat (4) @(posedge hclk);
		rd_chk(12'h110, 32'h1);
		rd_chk(12'h53c, 32'h1);
		rd_chk(12'h144, 32'h1);
		bus(1'b1, 12'h000, 32'h1);
		bus(1'b1, 12'h14c, 32'h0);
		bus(1'b1, 12'h200, 32'h20);
		bus(1'b1, 12'h02c, 32'h1);
		repeat (4) @(posedge hclk);
		rd_chk(12'h14c, 32'h1);
		bus(1'b1, 12'h004, 32'h1);
		repeat (4) @(posedge hclk);
		bus(1'b1, 12'h500, 32'h0);
		repeat (3) @(posedge hclk);
		chk(gpio_oe, 32'h0);
		tally_and_finish();
	end
endmodule : dma_serial_port_tb

/* verification/serial_peer.sv */
`timescale 1ns/1ps
// ==================================================
// remote serial party, 16 clocks a bit
module serial_peer (
	input  wire logic       hclk,
	input  wire logic       tx_line,
	output logic            rx_line,
	output logic [7:0]      got
);
	initial begin
		rx_line = 1'b1;
		got = 8'h00;
		forever begin
			@(negedge tx_line);
			repeat (24) @(posedge hclk);
			for (int i = 0; i < 8; i++) begin
				got[i] = tx_line;
				repeat (16) @(posedge hclk);
			end
		end
	end

	// frame bits go out lowest first, then line idles high
	task automatic send(input logic [10:0] f, input int n);
		for (int k = 0; k < n; k++) begin
			rx_line <= f[k];
			repeat (16) @(posedge hclk);
		end
		rx_line <= 1'b1;
		repeat (32) @(posedge hclk);
	endtask : send
endmodule : serial_peer
